// file: rtl/tcp_pkg.sv
package tcp_pkg;
  // command A field layout
  localparam int unsigned CA_IOC_BIT = 31;
  localparam int unsigned CA_RSV_HI = 30;
  localparam int unsigned CA_RSV_LO = 26;
  localparam int unsigned CA_ALIGN_HI = 25;
  localparam int unsigned CA_ALIGN_LO = 24;
  localparam int unsigned CA_OFFS_HI = 20;
  localparam int unsigned CA_OFFS_LO = 16;
  localparam int unsigned CA_FIRST_BIT = 13;
  localparam int unsigned CA_LAST_BIT = 12;
  localparam int unsigned CA_SIZE_HI = 10;
  localparam int unsigned CA_SIZE_LO = 0;
  // command B field layout
  localparam int unsigned CB_TAG_HI = 31;
  localparam int unsigned CB_TAG_LO = 16;
  localparam int unsigned CB_LEN_HI = 10;
  localparam int unsigned CB_LEN_LO = 0;
  // buffer end alignment codes
  localparam logic [1:0] ALIGN_4 = 2'h0;
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;
  // word masks used to round a word count up to the alignment
  localparam logic [11:0] AMASK_4 = 12'h000;
  localparam logic [11:0] AMASK_16 = 12'h003;
  localparam logic [11:0] AMASK_32 = 12'h007;
  // host register byte offsets
  localparam logic [7:0] REG_CMD_A = 8'h00;
  localparam logic [7:0] REG_CMD_B = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_INT_STS = 8'h0c;
  localparam logic [7:0] REG_INT_MASK = 8'h10;
  localparam logic [7:0] REG_TX_STAT = 8'h14;
  localparam logic [7:0] REG_PHASE = 8'h18;
  // interrupt status bit positions
  localparam int unsigned IS_LOADED = 0;
  localparam int unsigned IS_TXERR = 1;
  localparam int unsigned IS_STAT = 2;
  localparam int unsigned IS_ORDER = 3;
  localparam int unsigned IS_W = 4;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0] RST_MASK = 4'h0;
  localparam logic [15:0] RST_TAG = 16'h0000;
  localparam logic [11:0] RST_CNT = 12'h000;
  // parser and host phases
  typedef enum logic [1:0] {PH_CMD_A, PH_CMD_B, PH_BODY} tcp_phase_type;
endpackage : tcp_pkg

// file: rtl/tcp_link_if.sv
`timescale 1ns/10ps
interface tcp_link_if;
  logic wr_vld; // one data fifo word this cycle
  logic [31:0] wr_data;
  logic txe_pls; // transmitter_error_flag event
  logic done_pls; // tx_buffer_loaded_flag event
  logic stat_vld; // packet status word
  logic [15:0] stat_tag;
  logic stat_err;
  modport host (output wr_vld, output wr_data, input txe_pls, input done_pls,
    input stat_vld, input stat_tag, input stat_err);
  modport dev (input wr_vld, input wr_data, output txe_pls, output done_pls,
    output stat_vld, output stat_tag, output stat_err);
endinterface : tcp_link_if

// file: rtl/tcp_dev.sv
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
// Summary of operation
// - two command words precede every buffer
// - host sends both words per buffer
// - differing command B within packet flags error
// - packet tag returned in status word
// - interrupt bit raises buffer-loaded flag
// - reserved command A bits written zero
// - end alignment padding dropped by device
// - host writes A, then B, then data
// - bytes before start offset are ignored
// - length mismatch versus received bytes flags error
module tcp_dev (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  tcp_link_if.dev LINK,
  output logic PAY_VLD_O,
  output logic [31:0] PAY_DATA_O,
  output logic [3:0] PAY_BE_O,
  output logic PAY_LAST_O
);
  import tcp_pkg::*;

  tcp_phase_type phase_q;
  logic [31:0] cmd_a_q;
  logic [31:0] pkt_b_q;
  logic in_pkt_q;
  logic pkt_err_q;
  logic [15:0] pkt_bytes_q;
  logic [11:0] widx_q;
  logic [11:0] total_q;
  logic [11:0] start_q;
  logic [11:0] end_q;

  logic [11:0] a_offs;
  logic [11:0] a_end;
  logic [11:0] a_words;
  logic [11:0] a_mask;
  logic [11:0] a_total;
  logic take_a;
  logic take_b;
  logic take_w;
  logic b_empty;
  logic buf_end;
  logic b_mismatch;
  logic orphan;
  logic [3:0] lane_en;
  logic [2:0] lane_cnt;
  logic [15:0] bytes_nx;
  logic len_bad;

  assign take_a = LINK.wr_vld && (phase_q == PH_CMD_A);
  assign take_b = LINK.wr_vld && (phase_q == PH_CMD_B);
  assign take_w = LINK.wr_vld && (phase_q == PH_BODY);

  // buffer geometry from command A; reserved bits 30:26 are not looked at
  always_comb begin
    a_offs = {7'h00, LINK.wr_data[CA_OFFS_HI:CA_OFFS_LO]};
    a_end = a_offs + {1'b0, LINK.wr_data[CA_SIZE_HI:CA_SIZE_LO]};
    a_words = 12'((a_end + 12'h003) >> 2);
    case (LINK.wr_data[CA_ALIGN_HI:CA_ALIGN_LO])
      ALIGN_16: a_mask = AMASK_16;
      ALIGN_32: a_mask = AMASK_32;
      // reserved code falls back to no padding rather than stalling
      default: a_mask = AMASK_4;
    endcase
    a_total = (a_words + a_mask) & ~a_mask;
  end

  // per byte lane: inside [start, end) means payload, else lead or pad
  generate
    for (genvar k = 0; k < 4; k++) begin : g_lane
      logic [11:0] pos;
      assign pos = {widx_q[9:0], 2'(k)};
      assign lane_en[k] = take_w && (pos >= start_q) && (pos < end_q);
    end
  endgenerate

  // count of payload bytes in the current word
  always_comb begin
    lane_cnt = 3'h0;
    for (int i = 0; i < 4; i++) begin
      lane_cnt = lane_cnt + {2'h0, lane_en[i]};
    end
  end

  // an empty buffer (no offset, no size) ends right at command B
  assign b_empty = (total_q == RST_CNT);
  assign buf_end = (take_b && b_empty) || (take_w && (widx_q == total_q - 12'h001));
  assign b_mismatch = take_b && in_pkt_q && !cmd_a_q[CA_FIRST_BIT] &&
                      (LINK.wr_data != pkt_b_q);
  assign orphan = take_b && !in_pkt_q && !cmd_a_q[CA_FIRST_BIT];

  // running byte total including this cycle's contribution
  always_comb begin
    bytes_nx = pkt_bytes_q;
    if (take_b && cmd_a_q[CA_FIRST_BIT]) begin
      bytes_nx = RST_TAG;
    end else if (take_w) begin
      bytes_nx = pkt_bytes_q + {13'h0000, lane_cnt};
    end
  end

  // length seen against command B length; a command B being written in this cycle is used directly
  always_comb begin
    if (take_b) begin
      len_bad = (bytes_nx != {5'h00, LINK.wr_data[CB_LEN_HI:CB_LEN_LO]});
    end else begin
      len_bad = (bytes_nx != {5'h00, pkt_b_q[CB_LEN_HI:CB_LEN_LO]});
    end
  end

  // word phase: command A, command B, then the buffer body
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      phase_q <= PH_CMD_A;
    end else begin
      case (phase_q)
        PH_CMD_A: if (take_a) phase_q <= PH_CMD_B;
        PH_CMD_B: if (take_b) phase_q <= b_empty ? PH_CMD_A : PH_BODY;
        PH_BODY: if (buf_end) phase_q <= PH_CMD_A;
        default: phase_q <= PH_CMD_A;
      endcase
    end
  end

  // geometry latched from command A
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cmd_a_q <= RST_WORD;
      total_q <= RST_CNT;
      start_q <= RST_CNT;
      end_q <= RST_CNT;
    end else if (take_a) begin
      cmd_a_q <= LINK.wr_data;
      total_q <= a_total;
      start_q <= a_offs;
      end_q <= a_end;
    end
  end

  // word position inside the buffer body
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      widx_q <= RST_CNT;
    end else if (take_b) begin
      widx_q <= RST_CNT;
    end else if (take_w) begin
      widx_q <= widx_q + 12'h001;
    end
  end

  // packet context: reference command B, byte total, error memory
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pkt_b_q <= RST_WORD;
      in_pkt_q <= 1'b0;
      pkt_err_q <= 1'b0;
      pkt_bytes_q <= RST_TAG;
    end else begin
      pkt_bytes_q <= bytes_nx;
      if (take_b && cmd_a_q[CA_FIRST_BIT]) begin
        // a new first segment restarts the packet even if one was open
        pkt_b_q <= LINK.wr_data;
        in_pkt_q <= 1'b1;
        pkt_err_q <= 1'b0;
      end else if (b_mismatch || orphan) begin
        pkt_err_q <= 1'b1;
        in_pkt_q <= 1'b1;
      end
      if (buf_end && cmd_a_q[CA_LAST_BIT]) begin
        in_pkt_q <= 1'b0;
      end
    end
  end

  // status word at the end of the last segment carries the tag unchanged
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      LINK.stat_vld <= 1'b0;
      LINK.stat_tag <= RST_TAG;
      LINK.stat_err <= 1'b0;
    end else begin
      LINK.stat_vld <= buf_end && cmd_a_q[CA_LAST_BIT];
      if (buf_end && cmd_a_q[CA_LAST_BIT]) begin
        LINK.stat_tag <= take_b ? LINK.wr_data[CB_TAG_HI:CB_TAG_LO]
                                : pkt_b_q[CB_TAG_HI:CB_TAG_LO];
        LINK.stat_err <= pkt_err_q || b_mismatch || orphan || len_bad;
      end
    end
  end

  // event pulses back to the host
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      LINK.txe_pls <= 1'b0;
      LINK.done_pls <= 1'b0;
    end else begin
      LINK.txe_pls <= b_mismatch || orphan ||
                      (buf_end && cmd_a_q[CA_LAST_BIT] && len_bad);
      LINK.done_pls <= buf_end && cmd_a_q[CA_IOC_BIT];
    end
  end

  // payload toward the mac; lead bytes and padding words never appear
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      PAY_VLD_O <= 1'b0;
      PAY_DATA_O <= RST_WORD;
      PAY_BE_O <= 4'h0;
      PAY_LAST_O <= 1'b0;
    end else begin
      PAY_VLD_O <= |lane_en;
      PAY_BE_O <= lane_en;
      PAY_LAST_O <= (|lane_en) && cmd_a_q[CA_LAST_BIT] &&
                    ({widx_q[9:0], 2'h3} >= end_q - 12'h001);
      if (take_w) begin
        PAY_DATA_O <= LINK.wr_data;
      end
    end
  end
endmodule : tcp_dev

// file: rtl/tcp_host.sv
`timescale 1ns/10ps
module tcp_host (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  tcp_link_if.host LINK,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  output logic IRQ_O
);
  import tcp_pkg::*;

  tcp_phase_type phase_q;
  logic [IS_W-1:0] sts_q;
  logic [IS_W-1:0] mask_q;
  logic [16:0] tx_stat_q;
  logic wr_a;
  logic wr_b;
  logic wr_d;
  logic refused;
  logic [IS_W-1:0] ev;

  assign wr_a = WR_I && (ADDR_I == REG_CMD_A);
  assign wr_b = WR_I && (ADDR_I == REG_CMD_B);
  assign wr_d = WR_I && (ADDR_I == REG_DATA);
  // B before A, or data before B, is dropped instead of corrupting the stream
  assign refused = (wr_b && phase_q != PH_CMD_B) || (wr_d && phase_q != PH_BODY);

  // order tracker: A opens a buffer at any time, B only after A
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      phase_q <= PH_CMD_A;
    end else if (wr_a) begin
      phase_q <= PH_CMD_B;
    end else if (wr_b && phase_q == PH_CMD_B) begin
      phase_q <= PH_BODY;
    end
  end

  // push accepted words onto the data fifo link
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      LINK.wr_vld <= 1'b0;
      LINK.wr_data <= RST_WORD;
    end else begin
      LINK.wr_vld <= (wr_a || wr_b || wr_d) && !refused;
      // reserved command A bits are forced to zero whatever software wrote
      LINK.wr_data <= wr_a ? {WDATA_I[31], 5'h00, WDATA_I[25:0]} : WDATA_I;
    end
  end

  // last packet status: error bit above the tag
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tx_stat_q <= 17'h00000;
    end else if (LINK.stat_vld) begin
      tx_stat_q <= {LINK.stat_err, LINK.stat_tag};
    end
  end

  assign ev = {refused, LINK.stat_vld, LINK.txe_pls, LINK.done_pls};

  // sticky status, write one to clear; a same-cycle event wins
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sts_q <= RST_MASK;
    end else if (WR_I && ADDR_I == REG_INT_STS) begin
      sts_q <= (sts_q & ~WDATA_I[IS_W-1:0]) | ev;
    end else begin
      sts_q <= sts_q | ev;
    end
  end

  // interrupt mask
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      mask_q <= RST_MASK;
    end else if (WR_I && ADDR_I == REG_INT_MASK) begin
      mask_q <= WDATA_I[IS_W-1:0];
    end
  end

  // level interrupt, one cycle behind the status bits
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(sts_q & mask_q);
    end
  end

  // read data stand in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      RDATA_O <= RST_WORD;
    end else if (RD_I) begin
      if (ADDR_I == REG_INT_STS) begin
        RDATA_O <= {28'h0000000, sts_q};
      end else if (ADDR_I == REG_INT_MASK) begin
        RDATA_O <= {28'h0000000, mask_q};
      end else if (ADDR_I == REG_TX_STAT) begin
        RDATA_O <= {15'h0000, tx_stat_q};
      end else if (ADDR_I == REG_PHASE) begin
        RDATA_O <= {30'h00000000, phase_q};
      end else begin
        RDATA_O <= RST_WORD;
      end
    end else begin
      RDATA_O <= RST_WORD;
    end
  end
endmodule : tcp_host

// file: test/tcp_link_checker.sv
`timescale 1ns/10ps
module tcp_link_checker (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic wr_vld,
  input wire logic [31:0] wr_data,
  input wire logic txe_pls,
  input wire logic done_pls,
  input wire logic stat_vld,
  input wire logic [15:0] stat_tag,
  input wire logic stat_err
);
  // one clock for both ends, so one default clocking and reset
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  // the device only reacts to words, so every event follows a link word
  chk_done_after_word: assert property (done_pls |-> $past(wr_vld))
    else $error("loaded flag without a preceding word");
  chk_stat_after_word: assert property (stat_vld |-> $past(wr_vld))
    else $error("status without a preceding word");
  chk_txe_after_word: assert property (txe_pls |-> $past(wr_vld))
    else $error("error flag without a preceding word");
  // a buffer needs at least two command words, so loaded and status pulses never repeat back to back
  chk_done_one_cycle: assert property (done_pls |=> !done_pls)
    else $error("loaded flag longer than one cycle");
  chk_stat_one_cycle: assert property (stat_vld |=> !stat_vld)
    else $error("status longer than one cycle");
  // tag and error change only in the cycle the status pulse stands
  chk_tag_held: assert property (!stat_vld |-> $stable(stat_tag))
    else $error("tag changed without status");
  chk_err_held: assert property (!stat_vld |-> $stable(stat_err))
    else $error("status error changed without status");
  chk_clean_no_txe: assert property (stat_vld && !stat_err |-> !txe_pls)
    else $error("error flag on a clean packet");
  cov_done: cover property (done_pls);
  cov_err_stat: cover property (stat_vld && stat_err);
  cov_ioc_word: cover property (wr_vld && wr_data[31]);
endmodule : tcp_link_checker

// file: test/testbench.sv
`timescale 1ns/10ps
module testbench;
  import tcp_pkg::*;
  logic CLK_I = 1'b0;
  logic ARST_N_I = 1'b0;
  logic [7:0] ADDR_I = 8'h00;
  logic [31:0] WDATA_I = 32'h0000_0000;
  logic WR_I = 1'b0;
  logic RD_I = 1'b0;
  logic [31:0] RDATA_O;
  logic IRQ_O;
  logic PAY_VLD_O;
  logic [31:0] PAY_DATA_O;
  logic [3:0] PAY_BE_O;
  logic PAY_LAST_O;
  int num_errors = 0;
  int n_compared = 0;
  logic [36:0] exp_q[$]; // expected {last, lanes, data}
  logic [31:0] d;
  logic [3:0] sts = 4'h0;
  logic [3:0] msk = 4'h0;
  logic [15:0] t;
  int o;
  int s;
  tcp_link_if link();
  tcp_host tcp_host_i (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .LINK(link), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .IRQ_O(IRQ_O));
  tcp_dev tcp_dev_i (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .LINK(link), .PAY_VLD_O(PAY_VLD_O),
    .PAY_DATA_O(PAY_DATA_O), .PAY_BE_O(PAY_BE_O), .PAY_LAST_O(PAY_LAST_O));
  tcp_link_checker tcp_link_checker_i (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
    .wr_vld(link.wr_vld), .wr_data(link.wr_data), .txe_pls(link.txe_pls),
    .done_pls(link.done_pls), .stat_vld(link.stat_vld), .stat_tag(link.stat_tag),
    .stat_err(link.stat_err));
  // free running clock
  always #4 CLK_I = ~CLK_I;
  task automatic complete_run;
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic cmp(input logic [36:0] got, input logic [36:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_pay(input logic [36:0] got, input logic [36:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t payload got %h expected %h", $time, got, exp);
    end
  endtask : cmp_pay
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK_I);
    ADDR_I <= a;
    WDATA_I <= v;
    WR_I <= 1'b1;
    @(posedge CLK_I);
    WR_I <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge CLK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CLK_I);
    RD_I <= 1'b0;
    #1 v = RDATA_O;
  endtask : rd
  // poll with a bound, then check level interrupt and clear by writing ones
  task automatic chk_sts;
    for (int i = 0; i < 8; i++) begin
      rd(REG_INT_STS, d);
      if (d === {28'h0, sts}) break;
    end
    cmp(d, {28'h0, sts});
    if (d !== {28'h0, sts}) complete_run;
    cmp(IRQ_O, |(sts & msk));
    wr(REG_INT_STS, {28'h0, sts});
    sts = 4'h0;
  endtask : chk_sts
  // one buffer; reserved bits set on purpose, the host must clear them
  task automatic send(input bit ioc, input int al, input int off, input int size,
    input bit fst, input bit lst, input logic [31:0] cb);
    int nw;
    int p;
    logic [31:0] w;
    logic [3:0] be;
    nw = (off + size + 3) / 4;
    nw = (al == 1) ? ((nw + 3) / 4) * 4 : (al == 2) ? ((nw + 7) / 8) * 8 : nw;
    wr(REG_CMD_A, {ioc, 5'h1f, al[1:0], 3'h0, off[4:0], 2'h0, fst, lst, 1'b0, size[10:0]});
    #1 cmp(link.wr_data[CA_RSV_HI:CA_RSV_LO], 5'h00);
    wr(REG_CMD_B, cb);
    for (int i = 0; i < nw; i++) begin
      w = $urandom;
      for (int k = 0; k < 4; k++) begin
        p = 4 * i + k;
        be[k] = (p >= off) && (p < off + size);
      end
      if (be != 4'h0) exp_q.push_back({lst && (off + size <= 4 * i + 4), be, w});
      wr(REG_DATA, w);
    end
    if (ioc) sts[IS_LOADED] = 1'b1;
  endtask : send
  // payload words compared in the cycle they stand
  always @(posedge CLK_I) begin
    if (ARST_N_I && PAY_VLD_O === 1'b1) begin
      if (exp_q.size() == 0) cmp_pay(1, 0);
      else cmp_pay({PAY_LAST_O, PAY_BE_O, PAY_DATA_O}, exp_q.pop_front());
    end
  end
  initial begin
    void'($urandom(32'h0d3d482d));
    repeat (6) @(posedge CLK_I);
    ARST_N_I <= 1'b1;
    wr(REG_INT_MASK, 32'h0000_0005);
    msk = 4'h5;
    // command B and data before any command A are refused
    wr(REG_CMD_B, $urandom);
    wr(REG_DATA, $urandom);
    sts = 4'h8;
    chk_sts;
    rd(REG_PHASE, d);
    cmp(d, 0);
    // every alignment code, random offset and size
    for (int a = 0; a < 4; a++) begin
      t = 16'($urandom);
      o = $urandom_range(31);
      s = $urandom_range(64, 1);
      send(a[0], a, o, s, 1'b1, 1'b1, {t, 5'h0, s[10:0]});
      sts[IS_STAT] = 1'b1;
      chk_sts;
      rd(REG_TX_STAT, d);
      cmp(d, {16'h0, t});
    end
    // two segments, second command B equal then differing
    for (int m = 0; m < 2; m++) begin
      t = 16'($urandom);
      send(1'b0, 0, 3, 9, 1'b1, 1'b0, {t, 5'h0, 11'd14});
      send(1'b1, 1, 1, 5, 1'b0, 1'b1, {t, 5'h0, 11'd14} ^ m);
      sts = m ? 4'h7 : 4'h5;
      chk_sts;
      rd(REG_TX_STAT, d);
      cmp(d, {15'h0, m[0], t});
    end
    // length field one byte longer than the data sent
    send(1'b0, 0, 0, 8, 1'b1, 1'b1, {t, 5'h0, 11'd9});
    sts = 4'h6;
    chk_sts;
    rd(REG_TX_STAT, d);
    cmp(d, {15'h0, 1'b1, t});
    // a later segment with no packet open is an error
    send(1'b0, 0, 0, 4, 1'b0, 1'b1, {t, 5'h0, 11'd4});
    sts = 4'h6;
    chk_sts;
    rd(REG_TX_STAT, d);
    cmp(d[16], 1'b1);
    rd(8'h40, d);
    cmp(d, 0);
    repeat (4) @(posedge CLK_I);
    cmp(exp_q.size(), 0);
    complete_run;
  end
endmodule : testbench
